// ### design/apc_attr_regs.svh
`ifndef APC_ATTR_REGS_SVH
`define APC_ATTR_REGS_SVH
// Function
// - status port read clears select latch
// - each write port write flips latch
// - data port read leaves latch alone
// - data registers written and read back
// - index low five bits pick register
// - index bit five routes video to palette
// - sixteen 6-bit entries map 4-bit pixel
// - mode bit seven takes bits 5:4 from select
// - mode bit six passes full 8-bit pixel
// - mode bit five zeroes pan until vsync
// - mode bit three blink or background intensity
// - mode bit two copies dot eight, C0-DF
// - mode bit one selects monochrome emulation
// - mode bit zero selects graphics handling
// - border register drives border colour
// - plane enable bits gate colour planes
// - plane bits 5:4 route status colour pair
// - pan value shifts left per mode table
// - index register readable at write port
// - select bits 3:2 give top index bits
// - mode bit seven uses four select bits

// host i/o ports
`define APC_PORT_WRITE      16'h03C0
`define APC_PORT_READ       16'h03C1
`define APC_PORT_STAT_MONO  16'h03BA
`define APC_PORT_STAT_COLR  16'h03DA
// data register indices
`define APC_IDX_MODE        5'h10
`define APC_IDX_BORDER      5'h11
`define APC_IDX_PLANE       5'h12
`define APC_IDX_PAN         5'h13
`define APC_IDX_CSEL        5'h14
// field positions
`define APC_IDX_SRC_BIT     5
`define APC_MODE_P54_BIT    7
`define APC_MODE_WIDE_BIT   6
`define APC_MODE_SPLIT_BIT  5
`define APC_MODE_BLINK_BIT  3
`define APC_MODE_LGFX_BIT   2
`define APC_MODE_MONO_BIT   1
`define APC_MODE_GFX_BIT    0
// writable masks, reserved bits read zero
`define APC_MASK_INDEX      8'h3F
`define APC_MASK_PAL        8'h3F
`define APC_MASK_MODE       8'hEF
`define APC_MASK_PLANE      8'h3F
`define APC_MASK_PAN        8'h0F
`define APC_MASK_CSEL       8'h0F
// reset values
`define APC_RST_REG         8'h00
// panning figures
`define APC_PAN_NINE_WRAP   4'h8
// line graphics code range top bits (C0..DF)
`define APC_LGFX_TOP        3'h6
`endif

// ### design/apc_attr_pkg.sv
package apc_attr_pkg;
    // address/data selection latch, one-hot
    typedef enum logic [1:0] {
        APC_SEL_INDEX = 2'b01,
        APC_SEL_DATA  = 2'b10
    } apc_sel_type;
    typedef logic [7:0] apc_byte_type;
endpackage

// ### design/apc_attr_ctrl.sv
`timescale 1ns/100ps
`include "apc_attr_regs.svh"
module apc_attr_ctrl #(
    parameter int PAL_ENTRIES = 16
) (
    input  wire logic                       clk_in,          // pixel clock, 100 MHz
    input  wire logic                       srst_in,         // sync reset, high
    input  wire logic [15:0]                io_addr_in,      // host i/o address
    input  wire logic                       io_wr_in,        // host OUT strobe
    input  wire logic                       io_rd_in,        // host IN strobe
    input  wire apc_attr_pkg::apc_byte_type io_wdata_in,     // host write data
    output logic      [7:0]                 io_rdata_out,    // host read data
    input  wire logic                       pix_valid_in,    // pixel slot valid
    output logic                            pix_ready_out,   // pixel slot taken
    input  wire logic [3:0]                 pix_planes_in,   // plane bits, graphics
    input  wire logic [7:0]                 pix_byte_in,     // 8-bit attribute, wide mode
    input  wire logic [7:0]                 text_attr_in,    // text attribute byte
    input  wire logic [7:0]                 text_char_in,    // text character code
    input  wire logic                       text_dot_in,     // font dot
    input  wire logic                       text_dot8_in,    // eighth dot of the cell
    input  wire logic                       text_ninth_in,   // slot is ninth column
    input  wire logic                       blink_phase_in,  // blink off phase
    input  wire logic                       border_in,       // slot outside active area
    input  wire logic                       line_cmp_in,     // line compare pulse
    input  wire logic                       vsync_in,        // vertical sync
    input  wire logic                       nine_dot_in,     // 9-dot text timing active
    output logic                            colour_valid_out,// colour index valid
    input  wire logic                       colour_ready_in, // converter accepts
    output logic      [7:0]                 colour_out,      // colour index to converter
    output logic      [1:0]                 status_route_out,// status port bits 5:4
    output logic      [3:0]                 pan_shift_out,   // pixels to shift left
    output logic                            mono_emul_out,   // monochrome emulation
    output logic                            gfx_mode_out     // graphics pixel handling
);
    import apc_attr_pkg::*;

    apc_sel_type sel_r;
    logic [5:0]  index_r;
    logic [5:0]  pal_r [PAL_ENTRIES];
    logic [7:0]  mode_r;
    logic [7:0]  border_r;
    logic [5:0]  plane_r;
    logic [3:0]  pan_r;
    logic [3:0]  csel_r;
    logic        pan_zero_r;

    logic wr_port;
    logic rd_data;
    logic rd_index;
    logic rd_stat;
    logic wr_data;
    assign wr_port  = io_wr_in && (io_addr_in == `APC_PORT_WRITE);
    assign rd_data  = io_rd_in && (io_addr_in == `APC_PORT_READ);
    assign rd_index = io_rd_in && (io_addr_in == `APC_PORT_WRITE);
    assign rd_stat  = io_rd_in && ((io_addr_in == `APC_PORT_STAT_MONO) || (io_addr_in == `APC_PORT_STAT_COLR));
    assign wr_data  = wr_port && (sel_r == APC_SEL_DATA);

    // selection latch; a write in the same cycle as a status read wins
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sel_r <= APC_SEL_INDEX;
        end else if (wr_port) begin
            unique case (sel_r)
                APC_SEL_INDEX: sel_r <= APC_SEL_DATA;
                APC_SEL_DATA:  sel_r <= APC_SEL_INDEX;
                default:       sel_r <= APC_SEL_INDEX;
            endcase
        end else if (rd_stat) begin
            sel_r <= APC_SEL_INDEX;
        end
    end

    // index register load
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            index_r <= 6'h00;
        end else if (wr_port && (sel_r == APC_SEL_INDEX)) begin
            index_r <= io_wdata_in[5:0];
        end
    end

    // palette entries
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < PAL_ENTRIES; i++) begin
                pal_r[i] <= 6'h00;
            end
        end else if (wr_data && !index_r[4]) begin
            pal_r[index_r[3:0]] <= io_wdata_in[5:0];
        end
    end

    // control data registers, reserved bits masked off
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode_r   <= `APC_RST_REG;
            border_r <= `APC_RST_REG;
            plane_r  <= 6'h00;
            pan_r    <= 4'h0;
            csel_r   <= 4'h0;
        end else if (wr_data) begin
            unique case (index_r[4:0])
                `APC_IDX_MODE:   mode_r   <= io_wdata_in & `APC_MASK_MODE;
                `APC_IDX_BORDER: border_r <= io_wdata_in;
                `APC_IDX_PLANE:  plane_r  <= io_wdata_in[5:0];
                `APC_IDX_PAN:    pan_r    <= io_wdata_in[3:0];
                `APC_IDX_CSEL:   csel_r   <= io_wdata_in[3:0];
                default: ;
            endcase
        end
    end

    // readback of the indexed register
    logic [7:0] data_rd;
    always_comb begin
        data_rd = 8'h00;
        if (!index_r[4]) begin
            data_rd = {2'b00, pal_r[index_r[3:0]]};
        end else begin
            unique case (index_r[4:0])
                `APC_IDX_MODE:   data_rd = mode_r;
                `APC_IDX_BORDER: data_rd = border_r;
                `APC_IDX_PLANE:  data_rd = {2'b00, plane_r};
                `APC_IDX_PAN:    data_rd = {4'h0, pan_r};
                `APC_IDX_CSEL:   data_rd = {4'h0, csel_r};
                default:         data_rd = 8'h00;
            endcase
        end
    end

    // host read data, registered one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            io_rdata_out <= 8'h00;
        end else if (rd_data) begin
            io_rdata_out <= data_rd;
        end else if (rd_index) begin
            io_rdata_out <= {2'b00, index_r};
        end else if (rd_stat) begin
            // routed colour pair on bits 5:4
            io_rdata_out <= {2'b00, status_route_out, 4'h0};
        end
    end

    // split-screen pan hold: cleared by vsync
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pan_zero_r <= 1'b0;
        end else if (line_cmp_in && mode_r[`APC_MODE_SPLIT_BIT]) begin
            pan_zero_r <= 1'b1;
        end else if (vsync_in || !mode_r[`APC_MODE_SPLIT_BIT]) begin
            pan_zero_r <= 1'b0;
        end
    end

    // effective shift from the pan value
    logic [3:0] pan_eff;
    logic [3:0] shift_nxt;
    assign pan_eff = pan_zero_r ? 4'h0 : pan_r;
    always_comb begin
        if (mode_r[`APC_MODE_WIDE_BIT]) begin
            shift_nxt = {2'b00, pan_eff[2:1]};
        end else if (nine_dot_in && !mode_r[`APC_MODE_GFX_BIT]) begin
            if (pan_eff == `APC_PAN_NINE_WRAP || pan_eff > `APC_PAN_NINE_WRAP) begin
                shift_nxt = 4'h0;
            end else begin
                shift_nxt = pan_eff + 4'h1;
            end
        end else begin
            shift_nxt = {1'b0, pan_eff[2:0]};
        end
    end

    // mode outputs and shift, registered
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pan_shift_out <= 4'h0;
            mono_emul_out <= 1'b0;
            gfx_mode_out  <= 1'b0;
        end else begin
            pan_shift_out <= shift_nxt;
            mono_emul_out <= mode_r[`APC_MODE_MONO_BIT];
            gfx_mode_out  <= mode_r[`APC_MODE_GFX_BIT];
        end
    end

    // attribute value: text cell or graphics planes
    logic [3:0] fg;
    logic [3:0] bg;
    logic       lgfx_code;
    logic       dot;
    logic [3:0] attr_val;
    logic [3:0] attr_gated;
    logic [5:0] pal_val;
    logic [7:0] colour_nxt;
    assign lgfx_code = (text_char_in[7:5] == `APC_LGFX_TOP);
    always_comb begin
        fg = text_attr_in[3:0];
        bg = mode_r[`APC_MODE_BLINK_BIT] ? {1'b0, text_attr_in[6:4]} : text_attr_in[7:4];
        if (text_ninth_in) begin
            dot = mode_r[`APC_MODE_LGFX_BIT] && lgfx_code && text_dot8_in;
        end else begin
            dot = text_dot_in;
        end
        if (mode_r[`APC_MODE_BLINK_BIT] && text_attr_in[7] && blink_phase_in) begin
            dot = 1'b0;
        end
        if (mode_r[`APC_MODE_GFX_BIT]) begin
            attr_val = pix_planes_in;
            if (mode_r[`APC_MODE_BLINK_BIT] && blink_phase_in) begin
                attr_val[3] = 1'b0;
            end
        end else begin
            attr_val = dot ? fg : bg;
        end
    end

    assign attr_gated = attr_val & plane_r[3:0];
    assign pal_val = pal_r[attr_gated];

    // colour index assembly
    always_comb begin
        if (border_in || !index_r[`APC_IDX_SRC_BIT]) begin
            colour_nxt = border_r;
        end else if (mode_r[`APC_MODE_WIDE_BIT]) begin
            colour_nxt = pix_byte_in;
        end else if (mode_r[`APC_MODE_P54_BIT]) begin
            colour_nxt = {csel_r, pal_val[3:0]};
        end else begin
            colour_nxt = {csel_r[3:2], pal_val};
        end
    end

    // two-entry skid buffer toward the converter
    logic [7:0] skid_r;
    logic       skid_v_r;
    logic       acc;
    logic       drain;
    assign acc   = pix_valid_in && pix_ready_out;
    assign drain = !colour_valid_out || colour_ready_in;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            colour_valid_out <= 1'b0;
            colour_out       <= 8'h00;
            skid_r           <= 8'h00;
            skid_v_r         <= 1'b0;
            pix_ready_out    <= 1'b0;
        end else begin
            pix_ready_out <= 1'b1;
            if (drain) begin
                if (skid_v_r) begin
                    colour_out       <= skid_r;
                    colour_valid_out <= 1'b1;
                    skid_v_r         <= 1'b0;
                end else begin
                    colour_out       <= colour_nxt;
                    colour_valid_out <= acc;
                end
            end else if (acc) begin
                skid_r        <= colour_nxt;
                skid_v_r      <= 1'b1;
                pix_ready_out <= 1'b0;
            end else begin
                pix_ready_out <= !skid_v_r;
            end
        end
    end

    // status pair from the last colour handed on
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status_route_out <= 2'b00;
        end else if (colour_valid_out && colour_ready_in) begin
            unique case (plane_r[5:4])
                2'b00: status_route_out <= {colour_out[2], colour_out[0]};
                2'b01: status_route_out <= {colour_out[5], colour_out[4]};
                2'b10: status_route_out <= {colour_out[3], colour_out[1]};
                2'b11: status_route_out <= {colour_out[7], colour_out[6]};
                default: status_route_out <= 2'b00;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_idx_write;
        wr_port && sel_r == APC_SEL_INDEX;
    endsequence
    sequence s_data_write;
        wr_port && sel_r == APC_SEL_DATA;
    endsequence

    a_stat_clears_latch: assert property (
        rd_stat && !wr_port |=> sel_r == APC_SEL_INDEX)
        else $error("status read did not clear latch");
    a_write_flips_latch: assert property (
        s_idx_write |=> sel_r == APC_SEL_DATA)
        else $error("index write did not flip latch");
    a_data_read_keeps: assert property (
        rd_data && !wr_port |=> $stable(sel_r))
        else $error("data read moved latch");
    a_index_load_read: assert property (
        s_idx_write ##1 !wr_port ##1 (rd_index && !wr_port)
        |=> io_rdata_out == {2'b00, $past(io_wdata_in[5:0], 3)})
        else $error("index readback wrong");
    a_mode_reserved_zero: assert property (
        mode_r[4] == 1'b0 and (rd_index |=> io_rdata_out[7:6] == 2'b00))
        else $error("reserved mode bit set");
    a_pan_split_hold: assert property (
        line_cmp_in && mode_r[`APC_MODE_SPLIT_BIT] ##1 !vsync_in |=> pan_zero_r)
        else $error("split pan hold lost");
    a_pan_restore_vsync: assert property (
        vsync_in && !line_cmp_in |=> !pan_zero_r)
        else $error("vsync did not restore pan");
    a_skid_no_loss: assert property ( // buffer holds stalled word
        colour_valid_out && !colour_ready_in |=> colour_valid_out && $stable(colour_out))
        else $error("stalled colour changed");
    a_ready_when_full: assert property ( // buffer back-pressure
        skid_v_r |-> !pix_ready_out)
        else $error("ready while skid full");
    a_wide_passes_byte: assert property (
        acc && drain && !skid_v_r && mode_r[`APC_MODE_WIDE_BIT] && !border_in && index_r[5]
        |=> colour_out == $past(pix_byte_in))
        else $error("wide pixel not passed");
    a_border_colour: assert property (
        acc && drain && !skid_v_r && border_in |=> colour_out == $past(border_r))
        else $error("border colour wrong");
endmodule

// ### test/apc_host_model.sv
`timescale 1ns/100ps
`include "apc_attr_regs.svh"
module apc_host_model (
    input  wire logic        clk_in,       // device clock
    output logic      [15:0] io_addr_out,  // port address
    output logic             io_wr_out,    // out strobe
    output logic             io_rd_out,    // in strobe
    output logic      [7:0]  io_wdata_out, // out data
    input  wire logic [7:0]  io_rdata_in   // in data
);
    // idle bus: strobes low, address and data show the inverse of the last value
    initial begin
        io_addr_out  = 16'hFFFF;
        io_wr_out    = 1'b0;
        io_rd_out    = 1'b0;
        io_wdata_out = 8'hFF;
    end
    // one out cycle, held across the sampling edge
    task automatic out_b(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        io_addr_out  = addr;
        io_wdata_out = data;
        io_wr_out    = 1'b1;
        @(negedge clk_in);
        io_wr_out    = 1'b0;
        io_addr_out  = ~addr;
        io_wdata_out = ~data;
    endtask
    // one in cycle, data taken one edge after the strobe
    task automatic in_b(input logic [15:0] addr, output logic [7:0] data);
        @(negedge clk_in);
        io_addr_out = addr;
        io_rd_out   = 1'b1;
        @(negedge clk_in);
        io_rd_out   = 1'b0;
        io_addr_out = ~addr;
        data        = io_rdata_in;
    endtask
    task automatic put_reg(input logic [7:0] idx, input logic [7:0] val);
        logic [7:0] junk;
        in_b(`APC_PORT_STAT_COLR, junk);
        out_b(`APC_PORT_WRITE, idx);
        out_b(`APC_PORT_WRITE, val);
    endtask
    task automatic get_reg(input logic [7:0] idx, output logic [7:0] val);
        in_b(`APC_PORT_STAT_COLR, val);
        out_b(`APC_PORT_WRITE, idx);
        in_b(`APC_PORT_READ, val);
    endtask
endmodule

// ### test/tb_attribute_palette_controller.sv
`timescale 1ns/100ps
`include "apc_attr_regs.svh"
module tb_attribute_palette_controller;
    localparam logic [15:0] P_WR = `APC_PORT_WRITE;
    localparam logic [15:0] P_RD = `APC_PORT_READ;
    logic        clk_in;
    logic        srst_in;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        pix_valid;
    logic        pix_ready;
    logic [3:0]  pix_planes;
    logic [7:0]  pix_byte;
    logic        blink_phase;
    logic        border;
    logic        line_cmp;
    logic        vsync;
    logic        nine_dot;
    logic [7:0]  text_attr;
    logic [7:0]  text_char;
    logic        text_dot;
    logic        text_dot8;
    logic        text_ninth;
    logic        col_valid;
    logic        col_ready;
    logic [7:0]  col;
    logic [1:0]  route;
    logic [3:0]  pan;
    logic        mono;
    logic        gfx;
    int          num_errors;
    int          n_compared;
    int          cycles;

    apc_attr_ctrl i_apc_attr_ctrl (.clk_in(clk_in), .srst_in(srst_in), .io_addr_in(io_addr),
        .io_wr_in(io_wr), .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
        .pix_valid_in(pix_valid), .pix_ready_out(pix_ready), .pix_planes_in(pix_planes),
        .pix_byte_in(pix_byte), .text_attr_in(text_attr), .text_char_in(text_char), .text_dot_in(text_dot),
        .text_dot8_in(text_dot8), .text_ninth_in(text_ninth), .blink_phase_in(blink_phase),
        .border_in(border), .line_cmp_in(line_cmp), .vsync_in(vsync), .nine_dot_in(nine_dot),
        .colour_valid_out(col_valid), .colour_ready_in(col_ready), .colour_out(col),
        .status_route_out(route), .pan_shift_out(pan), .mono_emul_out(mono), .gfx_mode_out(gfx));
    apc_host_model i_apc_host_model (.clk_in(clk_in), .io_addr_out(io_addr), .io_wr_out(io_wr),
        .io_rd_out(io_rd), .io_wdata_out(io_wdata), .io_rdata_in(io_rdata));

    // clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            final_report();
        end
    end
    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] pal(input int k);
        return 8'((k * 13 + 7) % 64);
    endfunction
    // colour with select bits 3:2 = 11
    function automatic logic [7:0] cexp(input int k);
        return {2'b11, 6'(pal(k))};
    endfunction
    task automatic put(input logic [7:0] idx, input logic [7:0] val);
        i_apc_host_model.put_reg(idx, val);
    endtask
    // hand one slot over and wait until it is taken
    task automatic send_pix(input logic [3:0] planes, input logic [7:0] byt);
        int n;
        @(negedge clk_in);
        pix_planes = planes;
        pix_byte   = byt;
        pix_valid  = 1'b1;
        n = 0;
        while (pix_ready !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        // a slot never taken counts as a mismatch
        if (pix_ready !== 1'b1) begin
            chk("pix ready wait", 8'h01, {7'h00, pix_ready});
        end
        @(negedge clk_in);
        pix_valid = 1'b0;
    endtask
    task automatic pix_chk(input string what, input logic [3:0] planes, input logic [7:0] exp);
        send_pix(planes, 8'h00);
        chk("colour valid", 8'h01, {7'h00, col_valid});
        chk(what, exp, col);
    endtask
    task automatic t_latch();
        logic [7:0] v;
        i_apc_host_model.out_b(P_WR, 8'h10);
        i_apc_host_model.out_b(P_WR, 8'hFF);
        i_apc_host_model.in_b(P_WR, v);
        chk("index", 8'h10, v);
        i_apc_host_model.in_b(P_RD, v);
        chk("mode", 8'hEF, v);
        i_apc_host_model.out_b(P_WR, 8'h11);
        i_apc_host_model.in_b(P_RD, v);
        i_apc_host_model.out_b(P_WR, 8'h2A);
        i_apc_host_model.in_b(P_RD, v);
        chk("border", 8'h2A, v);
        i_apc_host_model.out_b(P_WR, 8'h12);
        i_apc_host_model.in_b(`APC_PORT_STAT_MONO, v);
        chk("status", 8'h00, v);
        i_apc_host_model.out_b(P_WR, 8'h13);
        i_apc_host_model.in_b(P_WR, v);
        chk("index after status", 8'h13, v);
        // unmapped write must not toggle the latch
        i_apc_host_model.out_b(16'h03C2, 8'h07);
        i_apc_host_model.out_b(P_WR, 8'h05);
        i_apc_host_model.get_reg(8'h13, v);
        chk("pan reg", 8'h05, v);
    endtask
    task automatic t_colour();
        logic [7:0] v;
        vsync = 1'b1; // loads in retrace
        for (int k = 0; k < 16; k++) put(8'(k), pal(k)); // bit five clear
        vsync = 1'b0;
        i_apc_host_model.get_reg(8'h05, v);
        chk("palette", pal(5), v);
        put(8'h10, 8'h01);
        put(8'h12, 8'h0F);
        put(8'h34, 8'h0E);
        for (int k = 0; k < 16; k++) pix_chk("palette colour", 4'(k), cexp(k));
        put(8'h30, 8'h81);
        pix_chk("select colour", 4'h9, {4'hE, 4'(pal(9))});
        put(8'h30, 8'h09);
        blink_phase = 1'b1;
        pix_chk("blink off", 4'hC, cexp(4));
        blink_phase = 1'b0;
        pix_chk("blink on", 4'hC, cexp(12));
        put(8'h30, 8'h01);
        put(8'h32, 8'h05);
        pix_chk("plane gate", 4'hF, cexp(5));
        put(8'h30, 8'h41);
        send_pix(4'h0, 8'hA7);
        chk("wide colour", 8'hA7, col);
        put(8'h30, 8'h01);
        put(8'h11, 8'h15);
        pix_chk("source off", 4'h3, 8'h15);
        put(8'h31, 8'h15);
        border = 1'b1;
        pix_chk("border", 4'h3, 8'h15);
        border = 1'b0;
        put(8'h32, 8'h0F);
    endtask
    task automatic t_stall();
        @(negedge clk_in);
        col_ready = 1'b0;
        send_pix(4'h1, 8'h00);
        send_pix(4'h2, 8'h00);
        chk("pix ready", 8'h00, {7'h00, pix_ready});
        chk("held colour", cexp(1), col);
        col_ready = 1'b1;
        @(negedge clk_in);
        chk("skid colour", cexp(2), col);
    endtask
    task automatic t_status();
        logic [7:0] c;
        logic [7:0] v;
        logic [1:0] e;
        c = cexp(6);
        for (int s = 0; s < 4; s++) begin
            put(8'h32, {2'b00, 2'(s), 4'hF});
            send_pix(4'h6, 8'h00);
            @(negedge clk_in);
            case (s)
                0: e = {c[2], c[0]};
                1: e = {c[5], c[4]};
                2: e = {c[3], c[1]};
                default: e = {c[7], c[6]};
            endcase
            i_apc_host_model.in_b(`APC_PORT_STAT_COLR, v);
            chk("status pair", {2'b00, e, 4'h0}, v);
        end
    endtask
    // text cells: intensity, blink and ninth dot
    task automatic t_text();
        text_attr = 8'hA1;
        put(8'h30, 8'h00);
        pix_chk("text intensity", 4'h0, cexp(10));
        put(8'h30, 8'h08);
        text_dot = 1'b1;
        pix_chk("text fg", 4'h0, cexp(1));
        blink_phase = 1'b1;
        pix_chk("text blink", 4'h0, cexp(2));
        blink_phase = 1'b0;
        put(8'h30, 8'h04);
        text_ninth = 1'b1;
        text_dot8  = 1'b1;
        text_char  = 8'hC5;
        pix_chk("ninth dot line", 4'h0, cexp(1));
        text_char  = 8'h41;
        pix_chk("ninth dot plain", 4'h0, cexp(10));
        text_ninth = 1'b0;
        text_dot   = 1'b0;
    endtask
    task automatic pan_chk(input logic [3:0] exp);
        @(negedge clk_in);
        @(negedge clk_in);
        chk("pan shift", {4'h0, exp}, {4'h0, pan});
    endtask
    task automatic t_pan();
        put(8'h33, 8'h03);
        put(8'h30, 8'h03);
        pan_chk(4'h3);
        chk("mode flags", 8'h03, {6'h00, mono, gfx});
        put(8'h30, 8'h00);
        nine_dot = 1'b1;
        // flags follow the mode register one cycle later
        @(negedge clk_in);
        chk("mode flags", 8'h00, {6'h00, mono, gfx});
        for (int p = 0; p < 9; p++) begin
            put(8'h33, 8'(p));
            pan_chk((p < 8) ? 4'(p + 1) : 4'h0);
        end
        nine_dot = 1'b0;
        put(8'h30, 8'h41);
        put(8'h33, 8'h06);
        pan_chk(4'h3);
        put(8'h30, 8'h21);
        put(8'h33, 8'h05);
        line_cmp = 1'b1;
        @(negedge clk_in);
        line_cmp = 1'b0;
        pan_chk(4'h0);
        vsync = 1'b1;
        @(negedge clk_in);
        vsync = 1'b0;
        pan_chk(4'h5);
        put(8'h30, 8'h01);
        line_cmp = 1'b1;
        @(negedge clk_in);
        line_cmp = 1'b0;
        pan_chk(4'h5);
    endtask
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        num_errors  = 0;
        n_compared  = 0;
        cycles      = 0;
        srst_in     = 1'b1;
        pix_valid   = 1'b0;
        pix_planes  = 4'h0;
        pix_byte    = 8'h00;
        blink_phase = 1'b0;
        border      = 1'b0;
        line_cmp    = 1'b0;
        vsync       = 1'b0;
        nine_dot    = 1'b0;
        text_attr   = 8'h00;
        text_char   = 8'h00;
        text_dot    = 1'b0;
        text_dot8   = 1'b0;
        text_ninth  = 1'b0;
        col_ready   = 1'b1;
        repeat (6) @(negedge clk_in);
        srst_in = 1'b0;
        t_latch();
        t_colour();
        t_stall();
        t_status();
        t_text();
        t_pan();
        final_report();
    end
endmodule
